// ---- hw/bccm_pkg.sv ----
// Package: constants for the background configuration CRC monitor
package bccm_pkg;
  // ****************************************
  // Register map (APB byte addresses)
  // ****************************************
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] status_addr = 8'h04;
  localparam logic [7:0] golden_addr = 8'h08;
  localparam logic [7:0] crc_addr = 8'h0c;
  localparam logic [7:0] mask_addr = 8'h10;
  localparam logic [7:0] pass_addr = 8'h14;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_status_pin_bit = 1;
  localparam int ctrl_continue_bit = 2;
  localparam int ctrl_clear_bit = 3;
  localparam int ctrl_code_lsb = 8;
  localparam int ctrl_code_w = 6;
  localparam logic [31:0] ctrl_reset = 32'h0000_0202;
  // ****************************************
  // Status fields
  // ****************************************
  localparam int st_err_bit = 0;
  localparam int st_busy_bit = 1;
  localparam int st_halt_bit = 2;
  localparam int st_golden_bit = 3;
  // ****************************************
  // CRC
  // ****************************************
  localparam logic [31:0] crc_poly = 32'h04c1_1db7;
  localparam logic [31:0] crc_init = 32'hffff_ffff;
  // Codes accepted for the scan clock, in order
  localparam int n_codes = 11;
  localparam logic [5:0] code_tab [n_codes] = '{6'd2, 6'd4, 6'd6, 6'd10, 6'd12, 6'd16,
    6'd22, 6'd26, 6'd33, 6'd40, 6'd50};
  localparam logic [5:0] code_default = 6'd2;
  typedef enum logic [1:0] {bccm_idle_s, bccm_golden_s, bccm_scan_s, bccm_stop_s} bccm_state_t;
endpackage

// ---- hw/bccm_crc32.sv ----
// One word step of the 32-bit scan CRC
`timescale 1ns/10ps
module bccm_crc32 (
  // Inputs
  input wire logic [31:0] crc_in,
  input wire logic [31:0] data,
  // Result
  output logic [31:0] crc_out
);
  logic [31:0] stage [33];
  assign stage[0] = crc_in;
  // Same update for golden and scan passes
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      assign stage[i+1] = (stage[i][31] ^ data[31-i]) ?
        ((stage[i] << 1) ^ bccm_pkg::crc_poly) : (stage[i] << 1);
    end
  endgenerate
  assign crc_out = stage[32];
endmodule

// ---- hw/bccm_clkdiv.sv ----
// Scan-rate enable from the chosen clock code
`timescale 1ns/10ps
module bccm_clkdiv (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic [5:0] code,
  // Enable
  output logic tick
);
  logic [5:0] cnt;
  // Higher code gives a faster scan; period 52 minus code cycles
  logic [5:0] limit;
  assign limit = 6'd51 - code;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 6'h00;
    end else if (cnt >= limit) begin
      cnt <= 6'h00;
    end else begin
      cnt <= cnt + 6'h01;
    end
  end
  assign tick = (cnt >= limit);
endmodule

// ---- hw/bccm_top.sv ----
// Background configuration CRC monitor with APB control
`timescale 1ns/10ps
module bccm_top #(
  parameter int frames = 64,
  parameter int words = 4
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration memory read port
  output logic [15:0] cfg_addr,
  output logic cfg_rd,
  input wire logic [31:0] cfg_data,
  input wire logic [31:0] cfg_mask,
  input wire logic cfg_bram_word,
  input wire logic cfg_pll_word,
  // Configuration events (pins, cross-domain)
  input wire logic done_pin,
  input wire logic end_session_command,
  input wire logic sync_word_seen,
  input wire logic jtag_tap_reset,
  input wire logic jtag_bus_req,
  input wire logic jtag_cfg_instr,
  input wire logic port_abort,
  input wire logic internal_reprogram_cmd,
  input wire logic suspend_active,
  input wire logic jtag_shutdown_state,
  input wire logic configuring,
  // Outputs
  output logic crc_mismatch_out,
  output logic init_pin_o,
  output logic init_pin_oe,
  output logic init_user_io_allowed,
  output logic boot_crc_err_update
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int n_in = 11;
  logic [n_in-1:0] raw_in;
  logic [n_in-1:0] sync1, sync2, sync3, level;
  assign raw_in = {done_pin, end_session_command, sync_word_seen, jtag_tap_reset,
    jtag_bus_req, jtag_cfg_instr, port_abort, internal_reprogram_cmd, suspend_active,
    jtag_shutdown_state, configuring};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      level <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= (sync2 & sync3) | (level & (sync2 | sync3));
    end
  end
  wire s_done = level[10];
  wire s_session_open = ~level[9];
  wire s_sync = level[8];
  wire s_tap_rst = level[7];
  wire s_jtag_req = level[6];
  wire s_jtag_instr = level[5];
  wire s_abort = level[4];
  wire s_reprog = level[3];
  wire s_suspend = level[2];
  wire s_shutdown = level[1];
  wire s_config = level[0];
  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl, golden, crc_snap, pass_cnt, mask_sel;
  logic err;
  bccm_pkg::bccm_state_t state, next_state;
  logic golden_ok;
  wire en = ctrl[bccm_pkg::ctrl_enable_bit];
  wire pin_report = ctrl[bccm_pkg::ctrl_status_pin_bit];
  wire cont = ctrl[bccm_pkg::ctrl_continue_bit];
  wire [5:0] code_w = pwdata[bccm_pkg::ctrl_code_lsb +: bccm_pkg::ctrl_code_w];
  // Unlisted codes keep the previous setting
  function automatic logic code_legal(input logic [5:0] c);
    logic ok;
    ok = 1'b0;
    for (int k = 0; k < bccm_pkg::n_codes; k++) begin
      ok = ok | (c == bccm_pkg::code_tab[k]);
    end
    return ok;
  endfunction
  wire wr = psel & penable & pwrite;
  wire wr_ctrl = wr & (paddr == bccm_pkg::ctrl_addr);
  wire wr_golden = wr & (paddr == bccm_pkg::golden_addr);
  wire wr_mask = wr & (paddr == bccm_pkg::mask_addr);
  wire mapped = (paddr == bccm_pkg::ctrl_addr) | (paddr == bccm_pkg::status_addr) |
    (paddr == bccm_pkg::golden_addr) | (paddr == bccm_pkg::crc_addr) |
    (paddr == bccm_pkg::mask_addr) | (paddr == bccm_pkg::pass_addr);
  wire sw_clear = wr_ctrl & pwdata[bccm_pkg::ctrl_clear_bit];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= bccm_pkg::ctrl_reset;
    end else if (wr_ctrl) begin
      ctrl[2:0] <= pwdata[2:0];
      if (code_legal(code_w)) begin
        ctrl[bccm_pkg::ctrl_code_lsb +: bccm_pkg::ctrl_code_w] <= code_w;
      end
    end
  end
  // Mask bit 0 masks both I/O port frames (first and last) together; LUT masking does not depend on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_sel <= 32'h0000_0000;
    end else if (wr_mask) begin
      mask_sel <= pwdata;
    end
  end
  wire [31:0] status = {28'h0, golden_ok, (state == bccm_pkg::bccm_stop_s),
    (state != bccm_pkg::bccm_idle_s), err};
  assign prdata = (paddr == bccm_pkg::ctrl_addr) ? ctrl :
    (paddr == bccm_pkg::status_addr) ? status :
    (paddr == bccm_pkg::golden_addr) ? golden :
    (paddr == bccm_pkg::crc_addr) ? crc_snap :
    (paddr == bccm_pkg::mask_addr) ? mask_sel :
    (paddr == bccm_pkg::pass_addr) ? pass_cnt : 32'h0000_0000;
  // ****************************************
  // Halt and run conditions
  // ****************************************
  wire halt = s_sync | s_session_open | s_tap_rst | s_abort | s_reprog | s_suspend |
    s_shutdown | s_jtag_instr;
  wire can_run = en & s_done & ~halt & ~s_config;
  // Scan rate enable
  logic tick;
  bccm_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .code(ctrl[bccm_pkg::ctrl_code_lsb +: bccm_pkg::ctrl_code_w]),
    .tick(tick)
  );
  // JTAG owns the bus; the scan just waits
  wire step = tick & ~s_jtag_req;
  // ****************************************
  // Frame walk and CRC
  // ****************************************
  localparam int aw = 16;
  logic [aw-1:0] word_idx;
  logic [31:0] crc_acc, crc_next, masked;
  wire last_word = (word_idx == aw'(frames * words - 1));
  wire frame_io = (word_idx < aw'(words)) | (word_idx >= aw'((frames - 1) * words));
  wire io_masked = frame_io & mask_sel[0];
  // Memory LUT columns, block RAM words and masked I/O frames are zeroed
  assign masked = (cfg_bram_word | io_masked) ? 32'h0000_0000 :
    (cfg_data & ~(cfg_pll_word ? 32'h0000_0000 : cfg_mask));
  bccm_crc32 u_crc (
    .crc_in(crc_acc),
    .data(masked),
    .crc_out(crc_next)
  );
  always_comb begin
    next_state = state;
    unique case (state)
      bccm_pkg::bccm_idle_s: begin
        if (can_run) begin
          next_state = golden_ok ? bccm_pkg::bccm_scan_s : bccm_pkg::bccm_golden_s;
        end
      end
      bccm_pkg::bccm_golden_s: begin
        if (!can_run) begin
          next_state = bccm_pkg::bccm_idle_s;
        end else if (step && last_word) begin
          next_state = bccm_pkg::bccm_scan_s;
        end
      end
      bccm_pkg::bccm_scan_s: begin
        if (!can_run) begin
          next_state = bccm_pkg::bccm_idle_s;
        end else if (step && last_word && (crc_next != golden) && !cont) begin
          next_state = bccm_pkg::bccm_stop_s;
        end
      end
      bccm_pkg::bccm_stop_s: begin
        if (!can_run) begin
          next_state = bccm_pkg::bccm_idle_s;
        end else if (!err) begin
          next_state = bccm_pkg::bccm_scan_s;
        end
      end
    endcase
  end
  wire active = (state == bccm_pkg::bccm_golden_s) | (state == bccm_pkg::bccm_scan_s);
  // Only a pass whose words were all really read may count or compare
  wire pass_end = active & can_run & step & last_word;
  wire mismatch = (state == bccm_pkg::bccm_scan_s) & pass_end & (crc_next != golden);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bccm_pkg::bccm_idle_s;
      word_idx <= '0;
      crc_acc <= bccm_pkg::crc_init;
    end else begin
      state <= next_state;
      if (!active || !can_run) begin
        word_idx <= '0;
        crc_acc <= bccm_pkg::crc_init;
      end else if (step) begin
        word_idx <= last_word ? '0 : word_idx + aw'(1);
        crc_acc <= last_word ? bccm_pkg::crc_init : crc_next;
      end
    end
  end
  assign cfg_addr = word_idx;
  assign cfg_rd = active & can_run & step;
  // Golden value: software load, recomputed after every halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      golden <= 32'h0000_0000;
      golden_ok <= 1'b0;
      crc_snap <= 32'h0000_0000;
      pass_cnt <= 32'h0000_0000;
    end else begin
      if (halt) begin
        golden_ok <= 1'b0;
      end else if (wr_golden) begin
        golden <= pwdata;
        golden_ok <= 1'b1;
      end else if ((state == bccm_pkg::bccm_golden_s) && pass_end) begin
        golden <= crc_next;
        golden_ok <= 1'b1;
      end
      if (pass_end) begin
        crc_snap <= crc_next;
        pass_cnt <= pass_cnt + 32'h0000_0001;
      end
    end
  end
  // ****************************************
  // Error flag and status pin
  // ****************************************
  // Mismatch wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= 1'b0;
    end else if (mismatch) begin
      err <= 1'b1;
    end else if (halt || !en || sw_clear) begin
      err <= 1'b0;
    end
  end
  assign crc_mismatch_out = err;
  assign boot_crc_err_update = 1'b0;
  // Pin stays with the config logic until configuration finishes
  wire pin_owned = en & s_done & ~s_config;
  assign init_pin_oe = pin_owned & pin_report & err;
  assign init_pin_o = 1'b0;
  assign init_user_io_allowed = ~en;
  // ****************************************
  // Checks
  // ****************************************
  a_mismatch_flag: assert property (@(posedge pclk) disable iff (!presetn)
    mismatch |=> crc_mismatch_out) else $error("mismatch not flagged");
  a_halt_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (halt && !mismatch) |=> !crc_mismatch_out) else $error("halt did not clear");
  a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (err && !halt && en && !sw_clear) |=> err) else $error("flag dropped");
  a_no_scan_early: assert property (@(posedge pclk) disable iff (!presetn)
    !s_done |-> !cfg_rd) else $error("scan before startup");
  a_jtag_wins: assert property (@(posedge pclk) disable iff (!presetn)
    s_jtag_req |-> !cfg_rd) else $error("scan during jtag");
  a_halt_policy: assert property (@(posedge pclk) disable iff (!presetn)
    (mismatch && !cont && can_run) |=> (state == bccm_pkg::bccm_stop_s))
    else $error("halt policy broken");
  a_continue_policy: assert property (@(posedge pclk) disable iff (!presetn)
    (mismatch && cont && can_run) |=> (state == bccm_pkg::bccm_scan_s))
    else $error("continue policy broken");
  a_pin_low: assert property (@(posedge pclk) disable iff (!presetn)
    (err && pin_report && pin_owned) |-> (init_pin_oe && !init_pin_o))
    else $error("status pin not low");
  a_pin_user: assert property (@(posedge pclk) disable iff (!presetn)
    en |-> !init_user_io_allowed) else $error("pin freed while enabled");
  c_golden_done: cover property (@(posedge pclk) disable iff (!presetn)
    (state == bccm_pkg::bccm_golden_s) ##1 (state == bccm_pkg::bccm_scan_s));
  c_mismatch: cover property (@(posedge pclk) disable iff (!presetn) mismatch);
  c_resume: cover property (@(posedge pclk) disable iff (!presetn)
    (state == bccm_pkg::bccm_stop_s) ##1 (state == bccm_pkg::bccm_scan_s));
endmodule

// ---- bench/bccm_cfg_model.sv ----
// Configuration memory model seen by the background scanner
`timescale 1ns/10ps
module bccm_cfg_model (
  // Scan port
  input wire logic [15:0] cfg_addr,
  input wire logic cfg_rd,
  // Bench control
  input wire logic [31:0] pattern,
  input wire logic upset,
  // Returned word
  output logic [31:0] cfg_data,
  output logic [31:0] cfg_mask,
  output logic cfg_bram_word,
  output logic cfg_pll_word
);
  logic [31:0] word;
  // Upset flips one bit of word 1
  assign word = pattern ^ {16'h0000, cfg_addr} ^ ((upset && cfg_addr == 16'h0001) ?
    32'h0000_0100 : 32'h0000_0000);
  // Not read: show junk, so a stale sample never passes
  assign cfg_data = cfg_rd ? word : ~word;
  // LUT memory in word 0 upper half, block RAM at word 2, PLL port at word 3
  assign cfg_mask = (cfg_addr == 16'h0000) ? 32'hffff_0000 :
    (cfg_addr == 16'h0003) ? 32'hffff_ffff : 32'h0000_0000;
  assign cfg_bram_word = (cfg_addr == 16'h0002);
  assign cfg_pll_word = (cfg_addr == 16'h0003);
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the background CRC monitor
`timescale 1ns/10ps
module tb_top;
  // ****
  // Signals
  // ****
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, p0, pat = 32'h0, cfg_data, cfg_mask;
  logic pready, pslverr, se, cfg_rd, err_o, pin_o, pin_oe, uio, boot, bram, pll;
  logic upset = 1'b0, done = 1'b1, es = 1'b1, jreq = 1'b0, jcfg = 1'b0, cfging = 1'b0;
  logic [15:0] cfg_addr;
  logic [5:0] ev = 6'h00;
  int miscompares = 0, num_checks = 0;
  always #50 pclk = ~pclk;
  bccm_top #(.frames(2), .words(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd),
    .cfg_data(cfg_data), .cfg_mask(cfg_mask), .cfg_bram_word(bram), .cfg_pll_word(pll),
    .done_pin(done), .end_session_command(es), .sync_word_seen(ev[0]),
    .jtag_tap_reset(ev[1]), .jtag_bus_req(jreq), .jtag_cfg_instr(jcfg),
    .port_abort(ev[2]), .internal_reprogram_cmd(ev[3]), .suspend_active(ev[4]),
    .jtag_shutdown_state(ev[5]), .configuring(cfging), .crc_mismatch_out(err_o),
    .init_pin_o(pin_o), .init_pin_oe(pin_oe), .init_user_io_allowed(uio),
    .boot_crc_err_update(boot));
  bccm_cfg_model model (.cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .pattern(pat), .upset(upset),
    .cfg_data(cfg_data), .cfg_mask(cfg_mask), .cfg_bram_word(bram), .cfg_pll_word(pll));
  // ****
  // Tasks
  // ****
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic wait_err(logic exp);
    int n;
    n = 0;
    while (err_o !== exp && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk("mismatch_flag", err_o, exp);
    if (n >= 3000) tally_and_finish();
  endtask
  // Scans advance: pass count must grow by k
  task automatic wait_pass(int k);
    int n;
    apb(1'b0, bccm_pkg::pass_addr, 32'h0);
    p0 = rd;
    n = 0;
    do begin
      apb(1'b0, bccm_pkg::pass_addr, 32'h0);
      n++;
    end while (rd < p0 + k && n < 500);
    if (n >= 500) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // Synchronizers need a few cycles before a stall counts
  task automatic stall_chk(string nm);
    repeat (10) @(posedge pclk);
    apb(1'b0, bccm_pkg::pass_addr, 32'h0);
    p0 = rd;
    repeat (60) @(posedge pclk);
    apb(1'b0, bccm_pkg::pass_addr, 32'h0);
    chk(nm, rd, p0);
  endtask
  function automatic logic [31:0] crc_of(logic [31:0] p, logic u, logic m);
    logic [31:0] c, d;
    logic fb;
    c = bccm_pkg::crc_init;
    for (int w = 0; w < 4; w++) begin
      d = p ^ 32'(w) ^ ((u && w == 1) ? 32'h0000_0100 : 32'h0);
      // Word 3 is the PLL word: its mask never applies
      if (w == 0) d = d & 32'h0000_ffff;
      if (w == 2 || m) d = 32'h0;
      for (int b = 31; b >= 0; b--) begin
        fb = c[31] ^ d[b];
        c = {c[30:0], 1'b0} ^ (fb ? bccm_pkg::crc_poly : 32'h0);
      end
    end
    return c;
  endfunction
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(32'h6f33));
    pat = $urandom();
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, bccm_pkg::ctrl_addr, 32'h0);
    chk("ctrl_reset", rd, bccm_pkg::ctrl_reset);
    chk("user_io_off", uio, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", se, 32'h1);
    apb(1'b1, bccm_pkg::ctrl_addr, 32'h0000_3203);
    wait_pass(2);
    apb(1'b0, bccm_pkg::crc_addr, 32'h0);
    chk("pass_crc", rd, crc_of(pat, 1'b0, 1'b0));
    apb(1'b0, bccm_pkg::status_addr, 32'h0);
    chk("golden_valid", rd[bccm_pkg::st_golden_bit], 32'h1);
    chk("no_mismatch", err_o, 32'h0);
    chk("user_io_on", uio, 32'h0);
    upset <= 1'b1;
    wait_err(1'b1);
    chk("pin_oe", pin_oe, 32'h1);
    chk("pin_o", pin_o, 32'h0);
    chk("boot_hist", boot, 32'h0);
    stall_chk("halt_policy");
    chk("flag_held", err_o, 32'h1);
    upset <= 1'b0;
    apb(1'b1, bccm_pkg::ctrl_addr, 32'h0000_320b);
    repeat (2) @(posedge pclk);
    chk("flag_clear", err_o, 32'h0);
    wait_pass(1);
    apb(1'b1, bccm_pkg::ctrl_addr, 32'h0000_3201);
    upset <= 1'b1;
    wait_err(1'b1);
    chk("pin_quiet", pin_oe, 32'h0);
    upset <= 1'b0;
    apb(1'b1, bccm_pkg::ctrl_addr, 32'h0000_320f);
    upset <= 1'b1;
    wait_err(1'b1);
    wait_pass(2);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      upset <= ~upset;
      wait_err(1'b1);
      ev[i] <= 1'b1;
      repeat (12) @(posedge pclk);
      chk("halt_clear", err_o, 32'h0);
      ev[i] <= 1'b0;
      wait_pass(2);
      chk("regolden", err_o, 32'h0);
    end
    done <= 1'b0;
    stall_chk("no_done");
    done <= 1'b1;
    jreq <= 1'b1;
    stall_chk("jtag_owns_bus");
    jreq <= 1'b0;
    es <= 1'b0;
    stall_chk("open_session");
    es <= 1'b1;
    jcfg <= 1'b1;
    stall_chk("cfg_instr_parked");
    jcfg <= 1'b0;
    for (int i = 0; i < bccm_pkg::n_codes; i++) begin
      apb(1'b1, bccm_pkg::ctrl_addr, {18'h0, bccm_pkg::code_tab[i], 8'h03});
      apb(1'b0, bccm_pkg::ctrl_addr, 32'h0);
      chk("clock_code", rd[13:8], bccm_pkg::code_tab[i]);
    end
    apb(1'b1, bccm_pkg::ctrl_addr, 32'h0000_0303);
    apb(1'b0, bccm_pkg::ctrl_addr, 32'h0);
    chk("bad_code", rd[13:8], 32'h32);
    apb(1'b1, bccm_pkg::mask_addr, 32'h0000_0001);
    apb(1'b1, bccm_pkg::ctrl_addr, 32'h0000_3207);
    wait_pass(2);
    apb(1'b0, bccm_pkg::crc_addr, 32'h0);
    chk("io_mask_crc", rd, crc_of(pat, 1'b0, 1'b1));
    wait_err(1'b1);
    apb(1'b1, bccm_pkg::ctrl_addr, 32'h0);
    repeat (2) @(posedge pclk);
    chk("disabled_io", uio, 32'h1);
    chk("disabled_flag", err_o, 32'h0);
    tally_and_finish();
  end
endmodule
